//--- shared/btac_pkg.sv
// Purpose: Constants and types for the bus time-out and alert control block
// Assumes: 10 MHz system clock, two-wire serial bus sampled synchronously
// Notes:   Pointer and upper slave address bits are fixed per build
package btac_pkg;
	// Register pointer of the control word on the serial bus
	localparam logic [7:0]  CTRL_PTR       = 8'h22;
	// Upper slave address bits; lower three come from the address pins
	localparam logic [3:0]  DEV_ADDR_HI    = 4'h3;
	localparam int          ADDR_PIN_W     = 3;
	localparam int          TO_DIS_BIT     = 7;
	localparam int          ALERT_DIS_BIT  = 0;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] CTRL_WR_MASK   = 16'h0081;
	localparam logic [15:0] READ_ZERO      = 16'h0000;
	localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
	// Clock rate and bus time-out
	localparam int          CLK_FREQ_KHZ   = 10000;
	localparam int          TIMEOUT_US     = 25000;
	localparam int          TIMEOUT_CYCLES = TIMEOUT_US * CLK_FREQ_KHZ / 1000;
	localparam int          TO_CNT_W       = 20;

	// Gray codes along the write transfer path
	typedef enum logic [3:0] {
		BTAC_IDLE     = 4'h0,
		BTAC_ADDR     = 4'h1,
		BTAC_ADDR_ACK = 4'h3,
		BTAC_PTR      = 4'h2,
		BTAC_PTR_ACK  = 4'h6,
		BTAC_WR_DATA  = 4'h7,
		BTAC_WR_ACK   = 4'h5,
		BTAC_RD_DATA  = 4'h4,
		BTAC_RD_ACK   = 4'hc
	} btac_state_t;
endpackage

//--- shared/btac_line_if.sv
// Purpose: Line events passed from the bus monitor to the transfer engine
// Assumes: All signals in the clk_sys domain
// Notes:   Event signals are one-cycle pulses
`timescale 1ns/1ps
interface btac_line_if;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic timeout;
	logic sda_s;
	logic timeout_en;

	modport mon (
		output scl_rise,
		output scl_fall,
		output start,
		output stop,
		output timeout,
		output sda_s,
		input  timeout_en
	);
	modport core (
		input  scl_rise,
		input  scl_fall,
		input  start,
		input  stop,
		input  timeout,
		input  sda_s,
		output timeout_en
	);
endinterface

//--- design/btac_line_mon.sv
// Purpose: Edge, start, stop and time-out detection on the serial bus lines
// Assumes: scl and sda are synchronous to clk_sys
// Notes:   Time-out counts only while enabled and the clock line is low
`timescale 1ns/1ps
module btac_line_mon #(
	parameter logic [19:0] TIMEOUT_CYC = 20'd250000
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       scl,
	input  wire logic       sda,
	btac_line_if.mon        line
);
	import btac_pkg::*;

	logic                scl_q_reg;
	logic                scl_d_reg;
	logic                sda_q_reg;
	logic                sda_d_reg;
	logic [TO_CNT_W-1:0] to_cnt_reg;
	logic [TO_CNT_W-1:0] to_cnt_next;
	logic                timeout_reg;
	logic                to_hit;

	assign line.scl_rise = scl_q_reg & ~scl_d_reg;
	assign line.scl_fall = ~scl_q_reg & scl_d_reg;
	assign line.start    = scl_q_reg & scl_d_reg & sda_d_reg & ~sda_q_reg;
	assign line.stop     = scl_q_reg & scl_d_reg & ~sda_d_reg & sda_q_reg;
	assign line.sda_s    = sda_q_reg;
	assign line.timeout  = timeout_reg;

	assign to_hit      = (to_cnt_reg == TIMEOUT_CYC - 20'd1);
	assign to_cnt_next = (line.timeout_en & ~scl_q_reg & ~to_hit) ?
		to_cnt_reg + 20'd1 : '0;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_q_reg   <= 1'b1;
			scl_d_reg   <= 1'b1;
			sda_q_reg   <= 1'b1;
			sda_d_reg   <= 1'b1;
			to_cnt_reg  <= '0;
			timeout_reg <= 1'b0;
		end else if (ce) begin
			scl_q_reg   <= scl;
			scl_d_reg   <= scl_q_reg;
			sda_q_reg   <= sda;
			sda_d_reg   <= sda_q_reg;
			to_cnt_reg  <= to_cnt_next;
			timeout_reg <= line.timeout_en & ~scl_q_reg & to_hit; // [RULE3]
		end
	end
endmodule

//--- design/btac_top.sv
// Purpose: Serial-bus slave holding the bus time-out and alert control word
// Assumes: External master drives the clock line; inputs synchronous
// Notes:   Data words go MSB byte first; other pointers read as zero
//
// Behaviour
// (RULE1) Act only as a bus slave answering an external clock-driving master.
// (RULE2) Assert the event output when temperature leaves the programmed limits.
// (RULE3) Bit 7 set disables the bus time-out; clear (default) enables it.
// (RULE4) Bit 0 set disables the bus alert; clear (default) enables it.
// (RULE5) Writes to both control bits are ignored while either lock is set.
// (RULE6) Reserved bits 15:8 and 6:1 read as zero and ignore writes.
`timescale 1ns/1ps
module btac_top #(
	parameter logic [19:0] TIMEOUT_CYC = 20'(btac_pkg::TIMEOUT_CYCLES)
) (
	input  wire logic                            clk_sys,
	input  wire logic                            rst,
	input  wire logic                            ce,
	input  wire logic                            scl_i,
	input  wire logic                            sda_i,
	output wire logic                            sda_o,
	output wire logic                            sda_oe,
	input  wire logic [btac_pkg::ADDR_PIN_W-1:0] addr_pins,
	input  wire logic                            crit_lock,
	input  wire logic                            window_lock,
	input  wire logic                            above_crit,
	input  wire logic                            above_window,
	input  wire logic                            below_window,
	output wire logic                            event_n,
	output wire logic                            bus_alert_n,
	output wire logic                            bus_timeout_disable,
	output wire logic                            bus_alert_disable
);
	import btac_pkg::*;

	default clocking ast_clk @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	btac_line_if line ();

	btac_state_t state_reg;
	btac_state_t state_next;
	logic [3:0]  bit_cnt_reg;
	logic [3:0]  bit_cnt_next;
	logic [7:0]  shift_reg;
	logic [7:0]  shift_next;
	logic [7:0]  tx_reg;
	logic [7:0]  tx_next;
	logic [7:0]  ptr_reg;
	logic [7:0]  ptr_next;
	logic [7:0]  hold_reg;
	logic [7:0]  hold_next;
	logic        rw_reg;
	logic        rw_next;
	logic        byte_idx_reg;
	logic        byte_idx_next;
	logic        acked_reg;
	logic        acked_next;
	logic        sda_oe_reg;
	logic        sda_oe_next;
	logic        sda_o_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic        event_n_reg;
	logic        alert_n_reg;
	logic        wr_commit;
	logic [7:0]  load_byte;

	wire         locked     = crit_lock | window_lock;
	wire         addr_match = (shift_reg[7:1] == {DEV_ADDR_HI, addr_pins});
	wire         byte_done  = line.scl_fall & (bit_cnt_reg == BITS_PER_BYTE);
	wire         ctrl_hit   = (ptr_reg == CTRL_PTR);
	wire [15:0]  rd_word    = ctrl_hit ? ctrl_reg : READ_ZERO;
	wire [15:0]  wr_word    = {hold_reg, shift_reg} & CTRL_WR_MASK; // [RULE6]
	wire         trip       = above_crit | above_window | below_window;
	wire         ctrl_wr_ok = wr_commit & ctrl_hit & ~locked; // [RULE5]

	assign line.timeout_en   = (state_reg != BTAC_IDLE) &
		~ctrl_reg[TO_DIS_BIT]; // [RULE3]
	assign sda_o               = sda_o_reg;
	assign sda_oe              = sda_oe_reg;
	assign event_n             = event_n_reg;
	assign bus_alert_n         = alert_n_reg;
	assign bus_timeout_disable = ctrl_reg[TO_DIS_BIT];
	assign bus_alert_disable   = ctrl_reg[ALERT_DIS_BIT];

	btac_line_mon #(
		.TIMEOUT_CYC (TIMEOUT_CYC)
	) u_mon (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.scl     (scl_i),
		.sda     (sda_i),
		.line    (line)
	);

	// Byte-level slave engine; only samples and drives data, never the clock
	always_comb begin
		state_next    = state_reg;
		bit_cnt_next  = bit_cnt_reg;
		shift_next    = shift_reg;
		tx_next       = tx_reg;
		ptr_next      = ptr_reg;
		hold_next     = hold_reg;
		rw_next       = rw_reg;
		byte_idx_next = byte_idx_reg;
		acked_next    = acked_reg;
		sda_oe_next   = sda_oe_reg;
		wr_commit     = 1'b0;
		load_byte     = byte_idx_reg ? rd_word[15:8] : rd_word[7:0];
		if (line.start) begin
			state_next   = BTAC_ADDR;
			bit_cnt_next = '0;
			sda_oe_next  = 1'b0;
		end else if (line.stop | line.timeout) begin
			state_next  = BTAC_IDLE; // [RULE3]
			sda_oe_next = 1'b0;
		end else begin
			unique case (state_reg)
			BTAC_IDLE: begin
			end
			BTAC_ADDR, BTAC_PTR, BTAC_WR_DATA: begin
				if (line.scl_rise) begin
					shift_next   = {shift_reg[6:0], line.sda_s};
					bit_cnt_next = bit_cnt_reg + 4'h1;
				end else if (byte_done) begin
					bit_cnt_next = '0;
					sda_oe_next  = 1'b1;
					if (state_reg == BTAC_ADDR) begin
						rw_next    = shift_reg[0];
						state_next = addr_match ? BTAC_ADDR_ACK : BTAC_IDLE;
						sda_oe_next = addr_match; // [RULE1]
					end else if (state_reg == BTAC_PTR) begin
						ptr_next   = shift_reg;
						state_next = BTAC_PTR_ACK;
					end else begin
						if (!byte_idx_reg)
							hold_next = shift_reg;
						wr_commit  = byte_idx_reg;
						state_next = BTAC_WR_ACK;
					end
				end
			end
			BTAC_ADDR_ACK: begin
				if (line.scl_fall) begin
					bit_cnt_next  = '0;
					byte_idx_next = 1'b0;
					if (rw_reg) begin
						state_next  = BTAC_RD_DATA;
						sda_oe_next = ~rd_word[15];
						tx_next     = {rd_word[14:8], 1'b0};
					end else begin
						state_next  = BTAC_PTR;
						sda_oe_next = 1'b0;
					end
				end
			end
			BTAC_PTR_ACK, BTAC_WR_ACK: begin
				if (line.scl_fall) begin
					sda_oe_next   = 1'b0;
					bit_cnt_next  = '0;
					byte_idx_next = (state_reg == BTAC_WR_ACK) ?
						~byte_idx_reg : 1'b0;
					state_next    = BTAC_WR_DATA;
				end
			end
			BTAC_RD_DATA: begin
				if (line.scl_rise) begin
					bit_cnt_next = bit_cnt_reg + 4'h1;
				end else if (byte_done) begin
					sda_oe_next = 1'b0;
					state_next  = BTAC_RD_ACK;
				end else if (line.scl_fall) begin
					sda_oe_next = ~tx_reg[7];
					tx_next     = {tx_reg[6:0], 1'b0};
				end
			end
			BTAC_RD_ACK: begin
				if (line.scl_rise) begin
					acked_next = ~line.sda_s;
				end else if (line.scl_fall) begin
					bit_cnt_next = '0;
					if (acked_reg) begin
						byte_idx_next = ~byte_idx_reg;
						state_next    = BTAC_RD_DATA;
						sda_oe_next   = ~load_byte[7];
						tx_next       = {load_byte[6:0], 1'b0};
					end else begin
						state_next = BTAC_IDLE;
					end
				end
			end
			endcase
		end
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		if (ctrl_wr_ok)
			ctrl_next = wr_word; // [RULE3] [RULE4] [RULE5]
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg    <= BTAC_IDLE;
			bit_cnt_reg  <= '0;
			shift_reg    <= '0;
			tx_reg       <= '0;
			ptr_reg      <= '0;
			hold_reg     <= '0;
			rw_reg       <= 1'b0;
			byte_idx_reg <= 1'b0;
			acked_reg    <= 1'b0;
			sda_oe_reg   <= 1'b0;
			sda_o_reg    <= 1'b0;
			ctrl_reg     <= CTRL_RESET; // [RULE3] [RULE4]
			event_n_reg  <= 1'b1;
			alert_n_reg  <= 1'b1;
		end else if (ce) begin
			state_reg    <= state_next;
			bit_cnt_reg  <= bit_cnt_next;
			shift_reg    <= shift_next;
			tx_reg       <= tx_next;
			ptr_reg      <= ptr_next;
			hold_reg     <= hold_next;
			rw_reg       <= rw_next;
			byte_idx_reg <= byte_idx_next;
			acked_reg    <= acked_next;
			sda_oe_reg   <= sda_oe_next;
			sda_o_reg    <= 1'b0; // [RULE1]
			ctrl_reg     <= ctrl_next;
			event_n_reg  <= ~trip; // [RULE2]
			alert_n_reg  <= ~(trip & ~ctrl_reg[ALERT_DIS_BIT]); // [RULE4]
		end
	end

	// Data line is only ever pulled low, never driven high
	AST_SDA_PULL_LOW: assert property (sda_oe |-> !sda_o) // [RULE1]
		else $error("data line driven high");

	sequence s_addr_seen;
		ce && state_reg == BTAC_ADDR && byte_done && addr_match
			&& !line.start && !line.stop && !line.timeout;
	endsequence
	AST_ADDR_ACK: assert property ( // [RULE1]
		s_addr_seen |=> sda_oe && state_reg == BTAC_ADDR_ACK)
		else $error("matching address not acknowledged");

	AST_EVENT_TRIP: assert property (ce && trip |=> !event_n) // [RULE2]
		else $error("event not asserted on trip");

	AST_TO_GATED: assert property ( // [RULE3]
		line.timeout |-> $past(line.timeout_en))
		else $error("time-out raised while disabled");

	AST_ALERT_GATED: assert property ( // [RULE4]
		!bus_alert_n |-> !$past(ctrl_reg[ALERT_DIS_BIT]) && $past(trip))
		else $error("alert asserted while disabled");

	sequence s_locked_write;
		ce && wr_commit && ctrl_hit && locked;
	endsequence
	AST_LOCK_HOLDS: assert property ( // [RULE5]
		s_locked_write |=> $stable(ctrl_reg))
		else $error("control changed while locked");

	AST_UNLOCK_WRITES: assert property ( // [RULE5]
		ce && wr_commit && ctrl_hit && !locked |=> ctrl_reg == $past(wr_word))
		else $error("unlocked write not taken");

	AST_RSVD_ZERO: assert property ( // [RULE6]
		(rd_word & ~CTRL_WR_MASK) == 16'h0000)
		else $error("reserved bits not zero");
endmodule

//--- tb/btac_host_bfm.sv
// Purpose: Bus master model driving clock and data lines
// Assumes: Lines change after the falling edge of clk_sys
// Notes:   Data line released (1) reads as pulled up
`timescale 1ns/1ps
module btac_host_bfm (
	input  wire logic clk_sys,
	input  wire logic sda_in,
	output logic      scl,
	output logic      sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Master owns the clock line
	task automatic xbit(input logic b, output logic r);
		scl = 1'b0;
		hold(2);
		sda_m = b;
		hold(3);
		scl = 1'b1;
		hold(3);
		r = sda_in;
		hold(2);
	endtask
	task automatic start;
		scl = 1'b0;
		hold(2);
		sda_m = 1'b1;
		hold(3);
		scl = 1'b1;
		hold(5);
		sda_m = 1'b0;
		hold(5);
	endtask
	task automatic stop;
		scl = 1'b0;
		hold(2);
		sda_m = 1'b0;
		hold(3);
		scl = 1'b1;
		hold(5);
		sda_m = 1'b1;
		hold(5);
	endtask
	// Eight bits MSB first, then the ninth bit
	task automatic xbyte(input logic [7:0] d, input logic l,
		output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], r[i]);
		end
		xbit(l, a);
	endtask
	task automatic stall(input int n);
		scl = 1'b0;
		hold(n);
	endtask
endmodule

//--- tb/testbench.sv
// Purpose: Self-checking bench for the control word slave
// Assumes: Short bus time-out of 50 cycles
// Notes:   Model holds the expected control word
`timescale 1ns/1ps
module testbench;
	import btac_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       ce = 1'b1;
	logic [2:0] addr_pins = 3'h0;
	logic [2:0] trip = 3'h0;
	logic       crit_lock = 1'b0;
	logic       window_lock = 1'b0;
	logic       scl, sda_m, sda_o, sda_oe, event_n, bus_alert_n, to_dis, al_dis;
	wire        sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
	int         miscompares = 0;
	int         total_checks = 0;
	int         mdl = 0;
	logic [7:0] r;
	logic [15:0] d;
	logic       a;

	always #50 clk_sys = ~clk_sys;
	btac_host_bfm host (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl),
		.sda_m(sda_m));
	btac_top #(.TIMEOUT_CYC(20'd50)) u_dut (.clk_sys(clk_sys), .rst(rst),
		.ce(ce), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .addr_pins(addr_pins), .crit_lock(crit_lock),
		.window_lock(window_lock), .above_crit(trip[2]),
		.above_window(trip[1]), .below_window(trip[0]),
		.event_n(event_n), .bus_alert_n(bus_alert_n),
		.bus_timeout_disable(to_dis), .bus_alert_disable(al_dis));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic addr(input logic rw, input logic ok);
		host.start;
		host.xbyte({DEV_ADDR_HI, addr_pins ^ {3{~ok}}, rw}, 1'b1, r, a);
		check(16'(a), 16'(!ok));
	endtask
	task automatic wr_word(input logic [7:0] p, input logic [15:0] v);
		addr(1'b0, 1'b1);
		host.xbyte(p, 1'b1, r, a);
		host.xbyte(v[15:8], 1'b1, r, a);
		host.xbyte(v[7:0], 1'b1, r, a);
		host.stop;
		if (p == CTRL_PTR && !(crit_lock || window_lock))
			mdl = v & 16'h0081;
		check({to_dis, al_dis}, {mdl[7], mdl[0]});
	endtask
	task automatic rd_word(input logic [7:0] p, output logic [15:0] v);
		addr(1'b0, 1'b1);
		host.xbyte(p, 1'b1, r, a);
		addr(1'b1, 1'b1);
		host.xbyte(8'hff, 1'b0, v[15:8], a);
		host.xbyte(8'hff, 1'b1, v[7:0], a);
		host.stop;
	endtask

	initial begin
		repeat (100000) @(posedge clk_sys);
		miscompares++;
		print_verdict;
	end
	initial begin
		void'($urandom(95995));
		addr_pins = 3'($urandom);
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		rd_word(CTRL_PTR, d);
		check(d, 16'(mdl));
		$display("test reset done");
		for (int i = 1; i <= 9; i++) begin
			{crit_lock, window_lock} = 2'(i);
			wr_word(CTRL_PTR, (i == 4) ? 16'hffff : 16'($urandom));
			rd_word(CTRL_PTR, d);
			check(d, 16'(mdl));
		end
		{crit_lock, window_lock} = 2'h0;
		$display("test locks done");
		wr_word(CTRL_PTR + 8'h01, 16'hffff);
		rd_word(CTRL_PTR + 8'h01, d);
		check(d, 16'h0000);
		rd_word(CTRL_PTR, d);
		check(d, 16'(mdl));
		addr(1'b0, 1'b0);
		host.stop;
		$display("test address done");
		for (int t = 0; t < 2; t++) begin
			wr_word(CTRL_PTR, {8'h00, 1'(t), 6'h00, 1'(t)});
			addr(1'b0, 1'b1);
			host.stall(80);
			host.xbyte(CTRL_PTR, 1'b1, r, a);
			check(16'(a), 16'(t == 0));
			host.stop;
			for (int k = 0; k < 6; k++) begin
				trip = 3'($urandom);
				repeat (2) @(negedge clk_sys);
				check(16'(event_n), 16'(trip == 3'h0));
				check(16'(bus_alert_n), 16'(trip == 3'h0 || t == 1));
			end
		end
		$display("test timeout and event done");
		trip = 3'h0;
		repeat (2) @(negedge clk_sys);
		ce = 1'b0;
		trip = 3'h7;
		repeat (4) @(negedge clk_sys);
		check(16'(event_n), 16'h0001);
		ce = 1'b1;
		repeat (2) @(negedge clk_sys);
		check(16'(event_n), 16'h0000);
		trip = 3'h0;
		rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		mdl = 0;
		rd_word(CTRL_PTR, d);
		check(d, 16'(mdl));
		$display("test enable and reset done");
		print_verdict;
	end
endmodule
